// File: hw/csc_consts.svh
// Offsets, field positions and reset values of the status, cancel and filter block.
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH
`define CSC_OFS_PROTO_STATUS 8'h44
`define CSC_OFS_TX_PENDING 8'hc8
`define CSC_OFS_TX_ADD 8'hd0
`define CSC_OFS_TX_CANCEL 8'hd4
`define CSC_OFS_CANCEL_DONE 8'hdc
`define CSC_OFS_TX_DONE_IE 8'he0
`define CSC_OFS_IRQ_STATUS 8'hf0
`define CSC_OFS_IRQ_MASK 8'hf4
`define CSC_OFS_RX_START 8'hf8
`define CSC_BIT_PROTO_EXC 14
`define CSC_BIT_FD_RX 13
`define CSC_BIT_RATE_SW 12
`define CSC_CFG_RXBUF 3'h7
`define CSC_ID2_ROUTE_HI 10
`define CSC_ID2_ROUTE_LO 9
`define CSC_ID2_EVT_HI 8
`define CSC_ID2_EVT_LO 6
`define CSC_ID2_IDX_HI 5
`define CSC_ID2_IDX_LO 0
`define CSC_IRQ_BIT_EXC 0
`define CSC_IRQ_BIT_FD 1
`define CSC_IRQ_BIT_CANCEL 2
`define CSC_IRQ_BIT_MATCH 3
`define CSC_RESET_WORD 32'h0000_0000
`endif

// File: hw/csc_pkg.sv
// Types of the status, cancel and filter block.
package csc_pkg;
   typedef enum logic [1:0] {
      CSC_ROUTE_STORE,
      CSC_ROUTE_DBG_A,
      CSC_ROUTE_DBG_B,
      CSC_ROUTE_DBG_C
   } csc_route_t;

   typedef struct packed {
      logic valid;
      logic [2:0] cfg_code;
      logic [10:0] second_id;
   } csc_match_t;

   typedef struct packed {
      logic valid;
      csc_route_t route;
      logic [15:0] buf_addr;
   } csc_store_t;

   typedef struct packed {
      logic valid;
      logic is_fd;
      logic rate_switch;
   } csc_rx_t;
endpackage

// File: hw/csc_core.sv
// Protocol status flags, transmit cancel tracking and extended filter routing.
//
// Functional notes
// - Protocol exception flag sets on event, clears when its register is read.
// - FD-received flag sets on any FDF frame, filtered or not; read clears.
// - Rate-switch bit holds BRS of last FD frame; read clears it.
// - Per-buffer cancel-finished bit sets when pending clears after cancel request.
// - Cancel of a buffer not pending sets its finished bit at once.
// - Writing one to an add-request bit clears that buffer's finished bit.
// - Config codes 001..110 mean second standard ID; 111 means buffer/debug.
// - Second ID bits 10:9 route: 00 store, 01/10/11 debug A/B/C.
// - Each set bit of second ID 8:6 pulses its event output one cycle.
// - Second ID bits 5:0 give buffer offset from the buffer start address.
`include "csc_consts.svh"

module csc_core #(
   parameter int NUM_TXB = 32,
   parameter int ELEM_BYTES = 72
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic proto_exc_evt,
   input wire csc_pkg::csc_rx_t rx_frame,
   input wire logic [NUM_TXB-1:0] tx_sent,
   input wire csc_pkg::csc_match_t filter_hit,
   output csc_pkg::csc_store_t store_req,
   output logic [2:0] filter_event,
   output logic [NUM_TXB-1:0] tx_request_pending,
   output logic irq
);
   import csc_pkg::*;

   // ---------------------------------------------------------------------
   // Parameter checks
   // ---------------------------------------------------------------------
   // The request registers are 32 bits wide, and the buffer address must fit
   // 16 bits for the largest offset of 63 elements.
   if (NUM_TXB < 1 || NUM_TXB > 32) begin : g_bad_txb
      $error("NUM_TXB must lie in 1..32.");
   end
   if (ELEM_BYTES < 1 || ELEM_BYTES > 1023) begin : g_bad_elem
      $error("ELEM_BYTES must lie in 1..1023.");
   end

   // ---------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] rdata;
      logic protocol_exception_flag;
      logic fd_frame_received_flag;
      logic last_rate_switch_flag;
      logic [NUM_TXB-1:0] pending;
      logic [NUM_TXB-1:0] cancel_req;
      logic [NUM_TXB-1:0] cancel_finished_bits;
      logic [31:0] tx_done_irq_enable;
      logic [3:0] irq_status;
      logic [3:0] irq_mask;
      logic [15:0] rx_buffer_start_addr;
      csc_store_t store;
      logic [2:0] fevt;
      logic irq;
   } csc_state_t;

   csc_state_t st_reg;
   csc_state_t st_next;
   logic [31:0] wr_add;
   logic [31:0] wr_cancel;
   logic [31:0] ps_word;
   logic rx_mode;

   // Write decodes for the request registers.
   assign wr_add = (reg_wr && reg_addr == `CSC_OFS_TX_ADD) ? reg_wdata : 32'h0000_0000;
   assign wr_cancel = (reg_wr && reg_addr == `CSC_OFS_TX_CANCEL) ? reg_wdata : 32'h0000_0000;
   assign rx_mode = filter_hit.valid && filter_hit.cfg_code == `CSC_CFG_RXBUF;

   // Protocol status word as software sees it.
   always_comb begin
      ps_word = 32'h0000_0000;
      ps_word[`CSC_BIT_PROTO_EXC] = st_reg.protocol_exception_flag;
      ps_word[`CSC_BIT_FD_RX] = st_reg.fd_frame_received_flag;
      ps_word[`CSC_BIT_RATE_SW] = st_reg.last_rate_switch_flag;
   end

   // ---------------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------------
   always_comb begin
      logic ps_rd;
      logic [3:0] ev;
      ps_rd = 1'b0;
      ev = 4'h0;
      st_next = st_reg;
      ps_rd = reg_rd && reg_addr == `CSC_OFS_PROTO_STATUS;

      if (ps_rd) begin
         st_next.protocol_exception_flag = 1'b0;
         st_next.fd_frame_received_flag = 1'b0;
         st_next.last_rate_switch_flag = 1'b0;
      end
      if (proto_exc_evt) begin
         st_next.protocol_exception_flag = 1'b1;
      end
      if (rx_frame.valid && rx_frame.is_fd) begin
         st_next.fd_frame_received_flag = 1'b1;
         st_next.last_rate_switch_flag = rx_frame.rate_switch;
      end

      // Per-buffer pending, cancel and finished tracking.
      for (int i = 0; i < NUM_TXB; i++) begin
         if (st_reg.pending[i] && (tx_sent[i] || st_reg.cancel_req[i])) begin
            st_next.pending[i] = 1'b0;
         end
         // finished when pending clears after cancel.
         if (st_reg.pending[i] && st_reg.cancel_req[i]) begin
            st_next.cancel_finished_bits[i] = 1'b1;
            st_next.cancel_req[i] = 1'b0;
            ev[`CSC_IRQ_BIT_CANCEL] = 1'b1;
         end
         if (wr_cancel[i]) begin
            if (st_reg.pending[i]) begin
               st_next.cancel_req[i] = 1'b1;
            end else begin
               st_next.cancel_finished_bits[i] = 1'b1;
               ev[`CSC_IRQ_BIT_CANCEL] = 1'b1;
            end
         end
         if (wr_add[i]) begin
            st_next.pending[i] = 1'b1;
            st_next.cancel_req[i] = 1'b0;
            st_next.cancel_finished_bits[i] = 1'b0;
         end
      end

      // buffer or debug routing of a match.
      st_next.store = '0;
      st_next.fevt = 3'h0;
      if (rx_mode) begin
         st_next.store.valid = 1'b1;
         st_next.store.route =
            csc_route_t'(filter_hit.second_id[`CSC_ID2_ROUTE_HI:`CSC_ID2_ROUTE_LO]);
         st_next.store.buf_addr = st_reg.rx_buffer_start_addr + 16'(ELEM_BYTES) *
            {10'h000, filter_hit.second_id[`CSC_ID2_IDX_HI:`CSC_ID2_IDX_LO]};
         st_next.fevt = filter_hit.second_id[`CSC_ID2_EVT_HI:`CSC_ID2_EVT_LO];
         ev[`CSC_IRQ_BIT_MATCH] = 1'b1;
      end
      ev[`CSC_IRQ_BIT_EXC] = proto_exc_evt;
      ev[`CSC_IRQ_BIT_FD] = rx_frame.valid && rx_frame.is_fd;

      // Register writes of plain storage and write-one clear of interrupt status.
      if (reg_wr) begin
         unique case (reg_addr)
            `CSC_OFS_TX_DONE_IE: st_next.tx_done_irq_enable = reg_wdata;
            `CSC_OFS_IRQ_MASK: st_next.irq_mask = reg_wdata[3:0];
            `CSC_OFS_RX_START: st_next.rx_buffer_start_addr = reg_wdata[15:0];
            `CSC_OFS_IRQ_STATUS: st_next.irq_status = st_reg.irq_status & ~reg_wdata[3:0];
            default: ;
         endcase
      end
      // Sticky interrupt status, event wins over write-one clear.
      st_next.irq_status = st_next.irq_status | ev;
      st_next.irq = |(st_next.irq_status & st_next.irq_mask);

      // Read data, valid in the cycle after the strobe.
      st_next.rdata = 32'h0000_0000;
      if (reg_rd) begin
         unique case (reg_addr)
            `CSC_OFS_PROTO_STATUS: st_next.rdata = ps_word;
            `CSC_OFS_TX_PENDING: st_next.rdata = 32'(st_reg.pending);
            `CSC_OFS_CANCEL_DONE: st_next.rdata = 32'(st_reg.cancel_finished_bits);
            `CSC_OFS_TX_DONE_IE: st_next.rdata = st_reg.tx_done_irq_enable;
            `CSC_OFS_IRQ_STATUS: st_next.rdata = {28'h0000000, st_reg.irq_status};
            `CSC_OFS_IRQ_MASK: st_next.rdata = {28'h0000000, st_reg.irq_mask};
            `CSC_OFS_RX_START: st_next.rdata = {16'h0000, st_reg.rx_buffer_start_addr};
            default: st_next.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign store_req = st_reg.store;
   assign filter_event = st_reg.fevt;
   assign tx_request_pending = st_reg.pending;
   assign irq = st_reg.irq;

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n || !clk_en);

   // ---------------------------------------------------------------------
   // Status flag checks
   // ---------------------------------------------------------------------
   // exception flag sets.
   a_exc_set: assert property (proto_exc_evt |=> st_reg.protocol_exception_flag)
      else $error("Exception flag not set after event.");
   a_exc_keep: assert property (
      proto_exc_evt && reg_rd && reg_addr == `CSC_OFS_PROTO_STATUS
      |=> st_reg.protocol_exception_flag)
      else $error("Exception event lost on clearing read.");
   a_fd_set: assert property (
      rx_frame.valid && rx_frame.is_fd |=> st_reg.fd_frame_received_flag)
      else $error("FD flag not set.");
   a_fd_plain: assert property (
      rx_frame.valid && !rx_frame.is_fd && !st_reg.fd_frame_received_flag
      |=> !st_reg.fd_frame_received_flag)
      else $error("Classic frame set the FD flag.");
   a_brs_track: assert property (
      rx_frame.valid && rx_frame.is_fd
      |=> st_reg.last_rate_switch_flag == $past(rx_frame.rate_switch))
      else $error("Rate-switch flag wrong.");
   a_brs_clear: assert property (
      reg_rd && reg_addr == `CSC_OFS_PROTO_STATUS && !rx_frame.valid
      |=> !st_reg.last_rate_switch_flag)
      else $error("Read did not clear rate-switch flag.");
   a_rd_clear: assert property (
      reg_rd && reg_addr == `CSC_OFS_PROTO_STATUS && !proto_exc_evt && !rx_frame.valid
      |=> !st_reg.protocol_exception_flag && !st_reg.fd_frame_received_flag)
      else $error("Read did not clear flags.");

   // ---------------------------------------------------------------------
   // Cancel tracking checks
   // ---------------------------------------------------------------------
   // idle cancel finishes at once.
   a_cancel_idle: assert property (
      wr_cancel[0] && !st_reg.pending[0] && !wr_add[0] |=> st_reg.cancel_finished_bits[0])
      else $error("Idle cancel not finished.");
   a_cancel_busy: assert property (
      wr_cancel[0] && st_reg.pending[0] && !wr_add[0] && !tx_sent[0] ##1 !wr_add[0]
      |=> st_reg.cancel_finished_bits[0] && !st_reg.pending[0])
      else $error("Pending cancel not finished.");
   a_add_clear: assert property (wr_add[0] |=> !st_reg.cancel_finished_bits[0])
      else $error("Add request did not clear finished bit.");

   // ---------------------------------------------------------------------
   // Filter routing checks
   // ---------------------------------------------------------------------
   // standard codes never store.
   a_std_nostore: assert property (
      filter_hit.valid && filter_hit.cfg_code != `CSC_CFG_RXBUF |=> !store_req.valid)
      else $error("Standard filter produced store.");
   a_route_sel: assert property (
      rx_mode |=> store_req.valid && store_req.route
      == csc_route_t'($past(filter_hit.second_id[`CSC_ID2_ROUTE_HI:`CSC_ID2_ROUTE_LO])))
      else $error("Route mismatch.");
   a_store_addr: assert property (
      rx_mode |=> store_req.buf_addr == 16'($past(st_reg.rx_buffer_start_addr)
      + ELEM_BYTES * $past(filter_hit.second_id[`CSC_ID2_IDX_HI:`CSC_ID2_IDX_LO])))
      else $error("Buffer address mismatch.");
   a_evt_set: assert property (
      rx_mode
      |=> filter_event == $past(filter_hit.second_id[`CSC_ID2_EVT_HI:`CSC_ID2_EVT_LO]))
      else $error("Filter event bits wrong.");
   a_evt_quiet: assert property (!rx_mode |=> filter_event == 3'h0)
      else $error("Filter event without a match.");
   a_evt_pulse: assert property (
      filter_event[0] && !(rx_mode && filter_hit.second_id[6]) |=> !filter_event[0])
      else $error("Filter event longer than one cycle.");

   // ---------------------------------------------------------------------
   // Coverage of the main scenarios
   // ---------------------------------------------------------------------
   c_cancel: cover property (wr_cancel[0] && st_reg.pending[0]
      ##2 st_reg.cancel_finished_bits[0]);
   c_store: cover property (store_req.valid && store_req.route == CSC_ROUTE_STORE);
   c_dbg: cover property (store_req.valid && store_req.route == CSC_ROUTE_DBG_C);
   c_keep: cover property (proto_exc_evt && reg_rd && reg_addr == `CSC_OFS_PROTO_STATUS);
endmodule // csc_core

// File: verif/csc_node_model.sv
// Far-side node model: drives reception, exception, sent and filter pulses.
module csc_node_model (
   output logic proto_exc_evt,
   output csc_pkg::csc_rx_t rx_frame,
   output logic [31:0] tx_sent,
   output csc_pkg::csc_match_t filter_hit,
   input wire logic mclk
);
   timeunit 1ns;
   timeprecision 1ps;
   import csc_pkg::*;

   // Every pulse is raised after an edge and dropped one edge later.
   initial begin
      proto_exc_evt = 1'b0;
      rx_frame = '0;
      tx_sent = '0;
      filter_hit = '0;
   end

   task automatic exc();
      @(posedge mclk);
      proto_exc_evt <= 1'b1;
      @(posedge mclk);
      proto_exc_evt <= 1'b0;
   endtask

   task automatic frame(input logic fd, input logic brs);
      @(posedge mclk);
      rx_frame <= '{valid: 1'b1, is_fd: fd, rate_switch: brs};
      @(posedge mclk);
      rx_frame <= '0;
   endtask

   task automatic hit(input logic [2:0] cfg, input logic [10:0] id);
      @(posedge mclk);
      filter_hit <= '{valid: 1'b1, cfg_code: cfg, second_id: id};
      @(posedge mclk);
      filter_hit <= '0;
   endtask

   // One-cycle transmission-completed pulse on the buffers of the mask.
   task automatic sent(input logic [31:0] mask);
      @(posedge mclk);
      tx_sent <= mask;
      @(posedge mclk);
      tx_sent <= '0;
   endtask
endmodule // csc_node_model

// File: verif/test_can_status_cancel_filter.sv
// Self-checking bench of the status, cancel and filter block.
module test_can_status_cancel_filter;
   timeunit 1ns;
   timeprecision 1ps;
   import csc_pkg::*;
   localparam int EB = 72;
   logic mclk, rst_n, clk_en, reg_wr, reg_rd, proto_exc_evt, irq;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv, tx_sent, pend;
   logic [2:0] filter_event;
   csc_rx_t rx_frame;
   csc_match_t filter_hit;
   csc_store_t store_req;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;

   csc_core #(.NUM_TXB(32), .ELEM_BYTES(EB)) i_csc_core (.mclk(mclk), .rst_n(rst_n),
      .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .proto_exc_evt(proto_exc_evt),
      .rx_frame(rx_frame), .tx_sent(tx_sent), .filter_hit(filter_hit),
      .store_req(store_req), .filter_event(filter_event), .tx_request_pending(pend),
      .irq(irq));
   csc_node_model i_csc_node_model (.proto_exc_evt(proto_exc_evt), .rx_frame(rx_frame),
      .tx_sent(tx_sent), .filter_hit(filter_hit), .mclk(mclk));

   // Clock and a cycle ceiling that cuts a hang short.
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask

   task automatic report_and_stop();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Read-to-clear status flags, including an event racing the clearing read.
   task automatic t_flags();
      i_csc_node_model.frame(1'b0, 1'b1);
      rd(8'h44);
      chk(32'(rv[14:12]), 32'h0);
      i_csc_node_model.exc();
      i_csc_node_model.frame(1'b1, 1'b0);
      i_csc_node_model.frame(1'b1, 1'b1);
      rd(8'h44);
      chk(32'(rv[14:12]), 32'h7);
      i_csc_node_model.frame(1'b1, 1'b1);
      i_csc_node_model.frame(1'b1, 1'b0);
      rd(8'h44);
      chk(32'(rv[14:12]), 32'h2);
      rd(8'h44);
      chk(32'(rv[14:12]), 32'h0);
      fork
         rd(8'h44);
         i_csc_node_model.exc();
      join
      rd(8'h44);
      chk(32'(rv[14]), 32'h1);
   endtask

   // A low clock enable ignores a register write and an exception event.
   task automatic t_freeze();
      @(posedge mclk);
      clk_en <= 1'b0;
      wr(8'he0, 32'h1234_5678);
      i_csc_node_model.exc();
      @(posedge mclk);
      clk_en <= 1'b1;
      rd(8'he0);
      chk(rv, 32'ha55a_0f0f);
      rd(8'h44);
      chk(32'(rv[14]), 32'h0);
   endtask

   // Register reset values, read-back and an unmapped address.
   task automatic t_regs();
      rd(8'he0);
      chk(rv, 32'h0);
      wr(8'he0, 32'ha55a_0f0f);
      rd(8'he0);
      chk(rv, 32'ha55a_0f0f);
      rd(8'hdc);
      chk(rv, 32'h0);
      rd(8'h40);
      chk(rv, 32'h0);
   endtask

   // Interrupt raised, cleared by writing one, then masked.
   task automatic t_irq();
      wr(8'hf0, 32'hf);
      wr(8'hf4, 32'h1);
      i_csc_node_model.exc();
      @(posedge mclk);
      #1 chk(32'(irq), 32'h1);
      wr(8'hf0, 32'h1);
      repeat (2) @(posedge mclk);
      #1 chk(32'(irq), 32'h0);
      wr(8'hf4, 32'h0);
      i_csc_node_model.exc();
      repeat (2) @(posedge mclk);
      #1 chk(32'(irq), 32'h0);
      rd(8'hf0);
      chk(32'(rv[0]), 32'h1);
   endtask

   // Cancel of pending and idle buffers, fresh add requests, then a plain send.
   task automatic t_cancel();
      wr(8'hd0, 32'h9);
      @(posedge mclk);
      #1 chk(pend, 32'h9);
      wr(8'hd4, 32'h9);
      repeat (3) @(posedge mclk);
      #1 chk(pend, 32'h0);
      rd(8'hdc);
      chk(rv, 32'h9);
      wr(8'hd4, 32'h21);
      rd(8'hdc);
      chk(rv, 32'h29);
      wr(8'hd0, 32'h0);
      rd(8'hdc);
      chk(rv, 32'h29);
      wr(8'hd0, 32'h21);
      rd(8'hdc);
      chk(rv, 32'h8);
      i_csc_node_model.sent(32'h20);
      rd(8'hc8);
      chk(rv, 32'h1);
      rd(8'hdc);
      chk(rv, 32'h8);
   endtask

   // Extended filter routing, event pulses and buffer address for each route.
   task automatic t_filter();
      logic [5:0] idx;
      logic [2:0] ev;
      wr(8'hf8, 32'h100);
      for (int r = 0; r < 4; r++) begin
         idx = 6'(r * 21);
         ev = 3'(r * 3);
         i_csc_node_model.hit(3'h7, {r[1:0], ev, idx});
         #1 chk(32'(store_req.valid), 32'h1);
         chk(32'(store_req.route), 32'(r));
         chk(32'(store_req.buf_addr), 32'h100 + EB * idx);
         chk(32'(filter_event), 32'(ev));
         @(posedge mclk);
         #1 chk(32'(filter_event), 32'h0);
      end
      i_csc_node_model.hit(3'h1, 11'h1ff);
      #1 chk(32'(store_req.valid), 32'h0);
   endtask

   // Main sequence.
   initial begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      clk_en = 1'b1;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      t_regs();
      t_flags();
      t_freeze();
      t_irq();
      t_cancel();
      t_filter();
      report_and_stop();
   end
endmodule // test_can_status_cancel_filter
